// ===== eeprom_link_pkg.sv
// Purpose: shared constants and carriers for the serial memory host link
// Assumes: 50 MHz core clock
// Notes:   clock ratios and byte framing live here
package eeprom_link_pkg;

  // ----------------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------------
  localparam int CORE_FREQ_HZ     = 50_000_000;
  localparam int SCLK_MAX_HZ      = 2_000_000;
  localparam int RATIO_SYNC_MIN   = 40;       // enhanced_sync_port floor
  localparam int RATIO_COMM_MIN   = 8;        // sync_comm_port floor
  // least divider that keeps the serial clock at or below its ceiling
  localparam int RATIO_RATE_MIN   = (CORE_FREQ_HZ + SCLK_MAX_HZ - 1)
                                    / SCLK_MAX_HZ;
  localparam int DIV_W            = 8;
  localparam int BITS_PER_BYTE    = 8;
  localparam int BIT_CNT_W        = 4;
  localparam logic [BIT_CNT_W-1:0] LAST_BIT = 4'h7;
  localparam logic [DIV_W-1:0]     DIV_ZERO = 8'h00;

  // ----------------------------------------------------------------------
  // attribute pin configuration
  // ----------------------------------------------------------------------
  localparam logic [1:0] ACCESS_TYPE_ATTR = 2'h2;   // plain attribute output
  localparam logic [1:0] ACCESS_TYPE_DRAM = 2'h3;
  localparam logic       POLARITY_RESET   = 1'h0;   // cleared: pin high

  typedef logic [BITS_PER_BYTE-1:0] byte_t;

  // one byte plus a flag that closes the frame after it
  typedef struct packed {
    byte_t data;
    logic  last;
  } txword_t;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_SETUP = 2'b01,
    ST_LOW   = 2'b11,
    ST_HIGH  = 2'b10
  } link_state_t;

endpackage : eeprom_link_pkg

// ===== eeprom_spi_link.sv
// Purpose: host side serial link to an spi memory, full duplex, mode 0
// Assumes: hold and write protect lines of the memory are pulled inactive
// Notes:   chip select driven only through the polarity bit
`timescale 1ns/10ps
`default_nettype none
module eeprom_spi_link
  import eeprom_link_pkg::*;
#(
  parameter bit          USE_COMM_PORT = 1'b0,   // 0 sync port, 1 comm port
  parameter int unsigned CLK_DIV       = 40      // core clocks per sclk
) (
  input  wire logic    clk,          // 50 MHz core clock
  input  wire logic    rst_n,        // async reset, active low
  input  wire txword_t txData,       // byte to send, last closes frame
  input  wire logic    txValid,      // txData offered
  output logic         txReady,      // buffer can take a byte
  output byte_t        rxData,       // byte caught during a send
  output logic         rxValid,      // rxData holds a byte
  input  wire logic    rxReady,      // consumer takes rxData
  output logic         serialClk,    // sync_port_clock_pin
  output logic         serialOut,    // sync_tx_data_pin
  input  wire logic    serialIn,     // sync_rx_data_pin
  output logic         attributePin, // attribute_pin_one, chip select low
  output logic [1:0]   accessType,   // access_type_field
  output logic         holdInactive  // hold kept high
);

  // ----------------------------------------------------------------------
  // divider limits
  // ----------------------------------------------------------------------
  localparam int RATIO_MIN = USE_COMM_PORT ? RATIO_COMM_MIN : RATIO_SYNC_MIN;
  localparam int DIV_USED  = (CLK_DIV < RATIO_MIN) ? RATIO_MIN :
                             ((CLK_DIV < RATIO_RATE_MIN) ? RATIO_RATE_MIN
                                                         : CLK_DIV);
  localparam logic [DIV_W-1:0] HALF_LOW  = DIV_W'(DIV_USED / 2 - 1);
  localparam logic [DIV_W-1:0] HALF_HIGH = DIV_W'(DIV_USED - DIV_USED / 2 - 1);

  typedef struct packed {
    logic             rs1;
    logic             rs2;
    txword_t [1:0]    tb;       // two-entry tx buffer
    logic    [1:0]    tbv;
    logic             tbw;      // write index
    logic             tbr;      // read index
    link_state_t      st;
    logic [DIV_W-1:0] div;
    logic [BIT_CNT_W-1:0] bitn;
    byte_t            sh;       // shift out
    byte_t            cap;      // shift in
    logic             lastByte;
    byte_t [1:0]      rb;       // two-entry rx buffer
    logic  [1:0]      rbv;
    logic             rbw;
    logic             rbr;
    logic             polarity; // pin_polarity_bit
    logic             sck;
    logic             sdo;
    logic             txRdy;
    logic             rxVld;
    byte_t            rxOut;
  } state_t;

  state_t s_r, s_nxt;

  function automatic logic full2(input logic [1:0] v);
    return &v;
  endfunction : full2

  // ----------------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------------
  // one process; the rx buffer must have room before a byte starts, so a
  // stalled consumer halts the link instead of dropping data; select stays
  // low through such a stall so the memory does not lose the frame
  always_comb begin
    logic txTake;
    logic rxTake;
    txTake = 1'b0;
    rxTake = 1'b0;
    s_nxt = s_r;
    s_nxt.rs1 = 1'b1;
    s_nxt.rs2 = s_r.rs1;
    if (s_r.txRdy && txValid) begin
      s_nxt.tb[s_r.tbw]  = txData;
      s_nxt.tbv[s_r.tbw] = 1'b1;
      s_nxt.tbw          = ~s_r.tbw;
    end
    if (s_r.rxVld && rxReady) begin
      rxTake              = 1'b1;
      s_nxt.rbv[s_r.rbr]  = 1'b0;
      s_nxt.rbr           = ~s_r.rbr;
    end
    unique case (s_r.st)
      ST_IDLE: begin
        s_nxt.sck = 1'b0;
        if (s_r.tbv[s_r.tbr] && !full2(s_r.rbv)) begin
          txTake          = 1'b1;
          s_nxt.sh        = s_r.tb[s_r.tbr].data;
          s_nxt.lastByte  = s_r.tb[s_r.tbr].last;
          s_nxt.polarity  = 1'b1;
          s_nxt.sdo       = s_r.tb[s_r.tbr].data[BITS_PER_BYTE-1];
          s_nxt.bitn      = '0;
          s_nxt.div       = HALF_LOW;
          s_nxt.st        = ST_SETUP;
        end else if (!s_r.tbv[s_r.tbr]) begin
          // nothing queued: the transfer is over, release the memory
          s_nxt.polarity  = 1'b0;
        end
      end
      ST_SETUP, ST_LOW: begin
        if (s_r.div == DIV_ZERO) begin
          s_nxt.sck = 1'b1;
          s_nxt.cap = {s_r.cap[BITS_PER_BYTE-2:0], serialIn};
          s_nxt.div = HALF_HIGH;
          s_nxt.st  = ST_HIGH;
        end else begin
          s_nxt.div = s_r.div - 1'b1;
        end
      end
      ST_HIGH: begin
        if (s_r.div == DIV_ZERO) begin
          s_nxt.sck = 1'b0;
          s_nxt.div = HALF_LOW;
          if (s_r.bitn == LAST_BIT) begin
            s_nxt.rb[s_r.rbw]  = s_r.cap;
            s_nxt.rbv[s_r.rbw] = 1'b1;
            s_nxt.rbw          = ~s_r.rbw;
            // keep select across bytes unless the frame ends here
            if (s_r.lastByte)
              s_nxt.polarity = 1'b0;
            s_nxt.st = ST_IDLE;
          end else begin
            s_nxt.sh   = {s_r.sh[BITS_PER_BYTE-2:0], 1'b0};
            s_nxt.sdo  = s_r.sh[BITS_PER_BYTE-2];
            s_nxt.bitn = s_r.bitn + 1'b1;
            s_nxt.st   = ST_LOW;
          end
        end else begin
          s_nxt.div = s_r.div - 1'b1;
        end
      end
    endcase
    if (txTake) begin
      s_nxt.tbv[s_r.tbr] = 1'b0;
      s_nxt.tbr          = ~s_r.tbr;
    end
    s_nxt.txRdy = ~s_nxt.tbv[s_nxt.tbw];
    s_nxt.rxVld = s_nxt.rbv[s_nxt.rbr];
    s_nxt.rxOut = s_nxt.rb[s_nxt.rbr];
    if (rxTake && !s_nxt.rxVld)
      s_nxt.rxOut = s_r.rxOut;
  end

  // ----------------------------------------------------------------------
  // registers, reset released through two flops
  // ----------------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_r          <= '0;
      s_r.polarity <= POLARITY_RESET;
    end else if (!s_r.rs2) begin
      s_r     <= '0;
      s_r.rs1 <= 1'b1;
      s_r.rs2 <= s_r.rs1;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ----------------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------------
  assign txReady      = s_r.txRdy;
  assign rxValid      = s_r.rxVld;
  assign rxData       = s_r.rxOut;
  assign serialClk    = s_r.sck;
  assign serialOut    = s_r.sdo;
  assign attributePin = ~s_r.polarity;
  assign accessType   = ACCESS_TYPE_ATTR;
  assign holdInactive = 1'b1;

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!s_r.rs2);

  a_select_idle: assert property (
    (s_r.st == ST_IDLE && !s_r.tbv[s_r.tbr]) |=> attributePin)
    else $error("select active while idle");
  a_clock_held: assert property (
    attributePin |-> !serialClk)
    else $error("clock toggles without select");
  a_high_min: assert property (
    $rose(serialClk) |-> serialClk [*4])
    else $error("serial clock high too short");
  a_low_min: assert property (
    $fell(serialClk) && !attributePin |-> !serialClk [*4])
    else $error("serial clock low too short");
  a_data_stable: assert property (
    serialClk |-> $stable(serialOut))
    else $error("data moved while clock high");
  a_access_type: assert property (
    accessType == ACCESS_TYPE_ATTR && accessType != ACCESS_TYPE_DRAM)
    else $error("bad access type");
  a_pin_polarity: assert property (
    (s_r.st != ST_IDLE) |-> !attributePin)
    else $error("select not low during a byte");
  a_rx_byte: assert property (
    (s_r.st == ST_HIGH && s_r.bitn == LAST_BIT && s_r.div == DIV_ZERO)
    |=> s_r.rbv[$past(s_r.rbw)])
    else $error("captured byte lost");
  a_hold_high: assert property (
    holdInactive)
    else $error("hold driven active");
  a_rate: assert property (
    $rose(serialClk) |=> !$rose(serialClk) [*8])
    else $error("serial clock too fast");

  c_frame: cover property ($fell(attributePin) ##[1:1000] $rose(attributePin));
  c_tx_full: cover property (!txReady);
  c_rx_stall: cover property (rxValid && !rxReady [*3]);
  c_two_bytes: cover property (rxValid && rxReady ##1 rxValid);

endmodule : eeprom_spi_link
`default_nettype wire

// ===== eeprom_mem_model.sv
// Purpose: behavioural serial memory for the host link bench
// Assumes: mode 0, memory output line pulled up
// Notes:   replies RESP_BASE xor byte index from the third byte on
`timescale 1ns/10ps
`default_nettype none
module eeprom_mem_model
  import eeprom_link_pkg::*;
#(
  parameter byte_t RESP_BASE = 8'h5a  // reply seed
) (
  input  wire logic sclk,  // clock from host
  input  wire logic selN,  // select, active low
  input  wire logic dIn,   // memory data input
  output logic      dOut   // memory data output
);
  // ------------------------------------------------------------
  // shift in, reply out
  // ------------------------------------------------------------
  byte_t shiftR;
  byte_t resp;
  int    bitCnt = 0;
  byte_t got[$];
  // capture on rise, only while selected; deselect restarts the count
  always @(posedge sclk or posedge selN) begin
    if (selN) begin
      bitCnt = 0;
    end else begin
      shiftR = {shiftR[6:0], dIn};
      bitCnt = bitCnt + 1;
      if (bitCnt % 8 == 0) got.push_back(shiftR);
    end
  end
  // reply driven on fall; line held high while deselected and through the first two bytes
  always @(negedge sclk or posedge selN) begin
    resp = RESP_BASE ^ byte_t'(bitCnt / 8);
    if (selN || bitCnt < 16) dOut <= 1'b1;
    else dOut <= resp[7 - bitCnt % 8];
  end
endmodule : eeprom_mem_model
`default_nettype wire

// ===== eeprom_spi_link_tb_top.sv
// Purpose: self-checking bench for the serial memory host link
// Assumes: 50 MHz clock, memory model on the far side
// Notes:   rx consumer stalls to fill both buffers
`timescale 1ns/10ps
`default_nettype none
module eeprom_spi_link_tb_top;
  import eeprom_link_pkg::*;
  localparam int DIV = 40;
  logic clk = 1'b0, rst_n = 1'b0, txValid = 1'b0, rxReady = 1'b0;
  txword_t txData = '0;
  logic txReady, rxValid, serialClk, serialOut, serialIn;
  logic attributePin, holdInactive;
  logic [1:0] accessType;
  byte_t rxData;
  int n_fail = 0, checks = 0;
  logic txValidC = 1'b0, rxReadyC = 1'b0;
  txword_t txDataC = '0;
  logic rxValidC, sclkC, sdoC, sdiC, selNC;
  byte_t rxDataC;
  always #10 clk = ~clk;
  eeprom_spi_link #(.USE_COMM_PORT(1'b0), .CLK_DIV(DIV)) dut (
    .clk(clk), .rst_n(rst_n), .txData(txData), .txValid(txValid),
    .txReady(txReady), .rxData(rxData), .rxValid(rxValid),
    .rxReady(rxReady), .serialClk(serialClk), .serialOut(serialOut),
    .serialIn(serialIn), .attributePin(attributePin),
    .accessType(accessType), .holdInactive(holdInactive));
  eeprom_mem_model mem (.sclk(serialClk), .selN(attributePin),
    .dIn(serialOut), .dOut(serialIn));
  // comm port variant, divider asked below the rate ceiling
  eeprom_spi_link #(.USE_COMM_PORT(1'b1), .CLK_DIV(8)) dutComm (
    .clk(clk), .rst_n(rst_n), .txData(txDataC), .txValid(txValidC),
    .txReady(), .rxData(rxDataC), .rxValid(rxValidC),
    .rxReady(rxReadyC), .serialClk(sclkC), .serialOut(sdoC),
    .serialIn(sdiC), .attributePin(selNC), .accessType(),
    .holdInactive());
  eeprom_mem_model memC (.sclk(sclkC), .selN(selNC), .dIn(sdoC),
    .dOut(sdiC));
  // ------------------------------------------------------------
  // shared tasks
  // ------------------------------------------------------------
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // txValid stays up between bytes so it is never set twice at once
  task automatic send(input byte_t d, input logic l);
    logic rdy;
    txData = '{data: d, last: l};
    txValid = 1'b1;
    for (int i = 0; i < 3000; i++) begin
      rdy = txReady;
      @(posedge clk);
      #1;
      if (rdy === 1'b1) return;
    end
    chk(8'h00, 8'h01);
  endtask : send
  task automatic recv(input byte_t exp);
    for (int i = 0; i < 3000; i++) begin
      @(posedge clk);
      #1;
      if (rxValid === 1'b1) begin
        chk(rxData, exp);
        rxReady = 1'b1;
        @(posedge clk);
        #1;
        rxReady = 1'b0;
        return;
      end
    end
    chk(8'h00, 8'h01);
  endtask : recv
  task automatic end_sim();
    $display("checks=%0d fails=%0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : end_sim
  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic t_idle();
    chk({7'h0, attributePin}, 8'h01);
    chk({6'h0, accessType}, {6'h0, ACCESS_TYPE_ATTR});
    chk({7'h0, holdInactive}, 8'h01);
    chk({7'h0, serialClk}, 8'h00);
    $display("test idle done");
  endtask : t_idle
  // read frame with the consumer stalled until both buffers fill; the
  // third byte then waits with select still low
  task automatic t_frame();
    send(8'h03, 1'b0);
    send(8'h1c, 1'b0);
    send(8'h00, 1'b0);
    send(8'h00, 1'b1);
    txValid = 1'b0;
    repeat (400) @(posedge clk);
    #1;
    chk({7'h0, txReady}, 8'h00);
    chk({7'h0, rxValid}, 8'h01);
    chk({7'h0, attributePin}, 8'h00);
    recv(8'hff);
    recv(8'hff);
    recv(8'h58);
    recv(8'h59);
    chk({7'h0, attributePin}, 8'h01);
    chk(mem.got[0], 8'h03);
    chk(mem.got[1], 8'h1c);
    $display("test frame done");
  endtask : t_frame
  // lone byte without last: select must still drop
  task automatic t_lone();
    int n;
    send(8'h06, 1'b0);
    txValid = 1'b0;
    n = 0;
    while (serialClk !== 1'b1 && n < 500) begin
      @(posedge clk);
      #1;
      n++;
    end
    n = 0;
    while (serialClk === 1'b1 && n < 500) begin
      @(posedge clk);
      #1;
      n++;
    end
    chk(8'(n), 8'(DIV / 2));
    recv(8'hff);
    repeat (2) @(posedge clk);
    #1;
    chk({7'h0, attributePin}, 8'h01);
    chk(8'(mem.got.size()), 8'h05);
    chk(mem.got[4], 8'h06);
    $display("test lone done");
  endtask : t_lone
  // comm variant asks for 8 core clocks; the 2 MHz ceiling makes it 25
  task automatic t_comm();
    int n;
    txDataC = '{data: 8'h9c, last: 1'b1};
    txValidC = 1'b1;
    @(posedge clk);
    #1;
    txValidC = 1'b0;
    n = 0;
    while (sclkC !== 1'b1 && n < 500) begin
      @(posedge clk);
      #1;
      n++;
    end
    n = 0;
    while (sclkC === 1'b1 && n < 500) begin
      @(posedge clk);
      #1;
      n++;
    end
    while (sclkC !== 1'b1 && n < 500) begin
      @(posedge clk);
      #1;
      n++;
    end
    chk(8'(n), 8'(RATIO_RATE_MIN));
    n = 0;
    while (rxValidC !== 1'b1 && n < 500) begin
      @(posedge clk);
      #1;
      n++;
    end
    chk(rxDataC, 8'hff);
    rxReadyC = 1'b1;
    @(posedge clk);
    #1;
    rxReadyC = 1'b0;
    chk({7'h0, selNC}, 8'h01);
    chk(memC.got[0], 8'h9c);
    $display("test comm done");
  endtask : t_comm
  // ------------------------------------------------------------
  // sequence and watchdog
  // ------------------------------------------------------------
  initial begin
    repeat (4) @(posedge clk);
    #1;
    rst_n = 1'b1;
    repeat (3) @(posedge clk);
    #1;
    t_idle();
    t_frame();
    t_lone();
    t_comm();
    end_sim();
  end
  // about 1900 cycles of traffic; generous margin
  initial begin
    repeat (20000) @(posedge clk);
    n_fail++;
    end_sim();
  end
endmodule : eeprom_spi_link_tb_top
`default_nettype wire
